//--- dac_buffer_reference_config.sv
// register bank for converter reference selection and output buffer op amp mode
//
// How it works
// - enable 1, range 10: internal reference everywhere
// - enable 1, range 00: input internal, outputs off
// - enable 0: input external; range 11 uses supply
// - range 01: external output reference, input external
// - reference power-down bit blocks internal reference
// - config bits 0,1: op amp on inputs 0/1, 2/3
// - config bits 2,3: op amp on inputs 4/5, 8/9
// - cleared config bit: buffer works as output stage
// - config update: first key, value, second key
// - range 00 powers down the converter output
`timescale 1ns/1ps
module dac_buffer_reference_config #(
    parameter int NUM_CONVERTERS = 4
) (
    input  wire logic                      clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      hsel_in,
    input  wire logic [31:0]               haddr_in,
    input  wire logic [1:0]                htrans_in,
    input  wire logic                      hwrite_in,
    input  wire logic [2:0]                hsize_in,
    input  wire logic [31:0]               hwdata_in,
    input  wire logic                      hready_in,
    output logic      [31:0]               hrdata_out,
    output logic                           hreadyout_out,
    output logic                           hresp_out,
    output logic                           adc_ref_internal_out,
    output logic                           internal_ref_power_down_out,
    output logic      [NUM_CONVERTERS-1:0] converter_power_down_out,
    output logic      [NUM_CONVERTERS-1:0] external_output_reference_out,
    output logic      [NUM_CONVERTERS-1:0] internal_reference_out,
    output logic      [NUM_CONVERTERS-1:0] analog_supply_reference_out,
    output logic      [3:0]                buffer_opamp_mode_out,
    output logic      [15:0]               opamp_input_connect_out
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (NUM_CONVERTERS < 1 || NUM_CONVERTERS > dac_ref_pkg::MAX_CONVERTERS) begin : g_bad_count
        $error("NUM_CONVERTERS must be 1 to 4");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0]              reference_control_reg;
    logic [7:0]              converter_ctl_reg [NUM_CONVERTERS];
    logic [3:0]              buffer_opamp_config_reg;
    logic [3:0]              staged_config_reg;
    dac_ref_pkg::key_state_t key_state_reg;
    dac_ref_pkg::key_state_t key_state_next;
    logic                    wr_valid_reg;
    logic [31:0]             wr_addr_reg;
    logic [31:0]             hrdata_reg;
    logic                    adc_internal_reg;
    logic                    ref_pd_reg;
    logic [3:0]              opamp_mode_reg;
    logic [15:0]             connect_reg;

    // ------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------
    wire addr_valid = hsel_in && htrans_in[1] && hready_in;
    wire rd_take    = addr_valid && !hwrite_in;
    wire wr_take    = addr_valid && hwrite_in;

    wire rd_ref    = (haddr_in == dac_ref_pkg::ADDR_REFERENCE_CONTROL);
    wire rd_cfg    = (haddr_in == dac_ref_pkg::ADDR_BUFFER_OPAMP_CONFIG);
    wire rd_status = (haddr_in == dac_ref_pkg::ADDR_REFERENCE_STATUS);

    // ------------------------------------------------------------
    // bus data phase write decode
    // ------------------------------------------------------------
    wire wr_ref  = wr_valid_reg && (wr_addr_reg == dac_ref_pkg::ADDR_REFERENCE_CONTROL);
    wire wr_key1 = wr_valid_reg && (wr_addr_reg == dac_ref_pkg::ADDR_BUFFER_UNLOCK_FIRST);
    wire wr_cfg  = wr_valid_reg && (wr_addr_reg == dac_ref_pkg::ADDR_BUFFER_OPAMP_CONFIG);
    wire wr_key2 = wr_valid_reg && (wr_addr_reg == dac_ref_pkg::ADDR_BUFFER_UNLOCK_SECOND);

    wire key1_ok = wr_key1 && (hwdata_in[15:0] == dac_ref_pkg::UNLOCK_FIRST_KEY);
    wire key2_ok = wr_key2 && (hwdata_in[15:0] == dac_ref_pkg::UNLOCK_SECOND_KEY);
    wire commit  = key2_ok && (key_state_reg == dac_ref_pkg::KEY_STAGED);
    wire stage   = wr_cfg && (key_state_reg == dac_ref_pkg::KEY_OPEN);

    // ------------------------------------------------------------
    // per converter decode and read mux
    // ------------------------------------------------------------
    logic [NUM_CONVERTERS-1:0] rd_ctl;
    logic [NUM_CONVERTERS-1:0] wr_ctl;
    logic [NUM_CONVERTERS-1:0] range_is_ext;
    logic [31:0]               ctl_rd [NUM_CONVERTERS+1];

    assign ctl_rd[0] = 32'h00000000;

    for (genvar i = 0; i < NUM_CONVERTERS; i++) begin : g_conv
        localparam logic [31:0] CTL_ADDR = dac_ref_pkg::ADDR_CONVERTER_CTL_BASE
                                         + dac_ref_pkg::ADDR_CONVERTER_CTL_STEP * i;
        assign rd_ctl[i]       = (haddr_in == CTL_ADDR);
        assign wr_ctl[i]       = wr_valid_reg && (wr_addr_reg == CTL_ADDR);
        assign range_is_ext[i] = (converter_ctl_reg[i][1:0] == dac_ref_pkg::RANGE_EXTERNAL);
        assign ctl_rd[i+1]     = ctl_rd[i] | (rd_ctl[i] ? {24'h000000, converter_ctl_reg[i]}
                                                        : 32'h00000000);

        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                converter_ctl_reg[i] <= dac_ref_pkg::CONVERTER_CTL_RESET;
            end else if (wr_ctl[i]) begin
                converter_ctl_reg[i] <= hwdata_in[7:0] & dac_ref_pkg::CONVERTER_CTL_MASK;
            end
        end

        converter_reference_decode u_decode (
            .clk_in            (clk_in),
            .rst_n_in          (rst_n_in),
            .range_in          (converter_ctl_reg[i][1:0]),
            .ref_enable_in     (reference_control_reg[dac_ref_pkg::REF_ENABLE_BIT]),
            .ref_power_down_in (reference_control_reg[dac_ref_pkg::REF_POWER_DOWN_BIT]),
            .power_down_out    (converter_power_down_out[i]),
            .external_ref_out  (external_output_reference_out[i]),
            .internal_ref_out  (internal_reference_out[i]),
            .supply_ref_out    (analog_supply_reference_out[i])
        );
    end

    wire [31:0] status_word = {24'h000000,
                               ref_pd_reg,
                               adc_internal_reg,
                               key_state_reg,
                               opamp_mode_reg};

    wire [31:0] read_word = ctl_rd[NUM_CONVERTERS]
                          | (rd_ref ? {30'h00000000, reference_control_reg} : 32'h00000000)
                          | (rd_cfg ? {28'h0000000, buffer_opamp_config_reg} : 32'h00000000)
                          | (rd_status ? status_word : 32'h00000000);

    // ------------------------------------------------------------
    // bus slave registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_valid_reg <= 1'b0;
            wr_addr_reg  <= 32'h00000000;
            hrdata_reg   <= 32'h00000000;
        end else begin
            wr_valid_reg <= wr_take;
            wr_addr_reg  <= haddr_in;
            hrdata_reg   <= rd_take ? read_word : 32'h00000000;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hreadyout_out <= 1'b0;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    assign hrdata_out = hrdata_reg;

    // ------------------------------------------------------------
    // reference control register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reference_control_reg <= dac_ref_pkg::REFERENCE_CTL_RESET;
        end else if (wr_ref) begin
            reference_control_reg <= hwdata_in[1:0] & dac_ref_pkg::REFERENCE_CTL_MASK;
        end
    end

    // ------------------------------------------------------------
    // key sequence for the buffer configuration
    // ------------------------------------------------------------
    always_comb begin
        key_state_next = key_state_reg;
        case (key_state_reg)
            dac_ref_pkg::KEY_IDLE: begin
                if (key1_ok) begin
                    key_state_next = dac_ref_pkg::KEY_OPEN;
                end
            end
            dac_ref_pkg::KEY_OPEN: begin
                if (wr_cfg) begin
                    key_state_next = dac_ref_pkg::KEY_STAGED;
                end else if (wr_key1 && !key1_ok) begin
                    key_state_next = dac_ref_pkg::KEY_IDLE;
                end else if (wr_key2) begin
                    key_state_next = dac_ref_pkg::KEY_IDLE;
                end
            end
            dac_ref_pkg::KEY_STAGED: begin
                if (key1_ok) begin
                    key_state_next = dac_ref_pkg::KEY_OPEN;
                end else if (wr_key1 || wr_key2 || wr_cfg) begin
                    key_state_next = dac_ref_pkg::KEY_IDLE;
                end
            end
            default: begin
                key_state_next = dac_ref_pkg::KEY_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            key_state_reg <= dac_ref_pkg::KEY_IDLE;
        end else begin
            key_state_reg <= key_state_next;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            staged_config_reg <= dac_ref_pkg::BUFFER_CONFIG_RESET;
        end else if (stage) begin
            staged_config_reg <= hwdata_in[3:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buffer_opamp_config_reg <= dac_ref_pkg::BUFFER_CONFIG_RESET;
        end else if (commit) begin
            buffer_opamp_config_reg <= staged_config_reg;
        end
    end

    // ------------------------------------------------------------
    // shared reference and op amp outputs
    // ------------------------------------------------------------
    wire adc_internal_next = reference_control_reg[dac_ref_pkg::REF_ENABLE_BIT]
                          && !reference_control_reg[dac_ref_pkg::REF_POWER_DOWN_BIT]
                          && !(|range_is_ext);

    logic [15:0] connect_next;

    always_comb begin
        connect_next = 16'h0000;
        for (int b = 0; b < dac_ref_pkg::BUFFER_CONFIG_BITS; b++) begin
            connect_next[dac_ref_pkg::OPAMP_POS_INPUT[b]] = buffer_opamp_config_reg[b];
            connect_next[dac_ref_pkg::OPAMP_NEG_INPUT[b]] = buffer_opamp_config_reg[b];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            adc_internal_reg <= 1'b0;
            ref_pd_reg       <= 1'b0;
            opamp_mode_reg   <= 4'h0;
            connect_reg      <= 16'h0000;
        end else begin
            adc_internal_reg <= adc_internal_next;
            ref_pd_reg       <= reference_control_reg[dac_ref_pkg::REF_POWER_DOWN_BIT];
            opamp_mode_reg   <= buffer_opamp_config_reg;
            connect_reg      <= connect_next;
        end
    end

    assign adc_ref_internal_out        = adc_internal_reg;
    assign internal_ref_power_down_out = ref_pd_reg;
    assign buffer_opamp_mode_out       = opamp_mode_reg;
    assign opamp_input_connect_out     = connect_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_key_commit_value: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        commit |=> buffer_opamp_config_reg == $past(staged_config_reg)
                   ##1 buffer_opamp_mode_out == $past(buffer_opamp_config_reg))
        else $error("second key did not commit the staged configuration");

    a_cfg_locked_ignore: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_cfg && key_state_reg == dac_ref_pkg::KEY_IDLE) |=>
            key_state_reg == dac_ref_pkg::KEY_IDLE && $stable(buffer_opamp_config_reg))
        else $error("configuration write without first key was not ignored");

    a_cfg_change_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $changed(buffer_opamp_config_reg) |-> $past(commit))
        else $error("configuration changed without the second key");

    a_adc_ref_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reference_control_reg == 2'h1 && !(|range_is_ext)) |=> adc_ref_internal_out)
        else $error("input converter did not take the internal reference");

    a_ext_blocks_adc: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (|range_is_ext) |=> !adc_ref_internal_out)
        else $error("range 01 left the input converter on the internal reference");

    a_ref_pd_blocks: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        internal_ref_power_down_out |-> !adc_ref_internal_out)
        else $error("internal reference used while powered down");

    a_opamp_first_pair: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        opamp_input_connect_out[1:0] == {2{buffer_opamp_mode_out[0]}}
        && opamp_input_connect_out[3:2] == {2{buffer_opamp_mode_out[1]}})
        else $error("op amp inputs 0 to 3 do not follow config bits 0 and 1");

    a_opamp_upper_pair: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        opamp_input_connect_out[5:4] == {2{buffer_opamp_mode_out[2]}}
        && opamp_input_connect_out[9:8] == {2{buffer_opamp_mode_out[3]}}
        && opamp_input_connect_out[7:6] == 2'h0)
        else $error("op amp inputs 4, 5, 8, 9 do not follow config bits 2 and 3");

    a_cfg_read_back: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rd_take && rd_cfg) |=> hrdata_out == {28'h0000000, $past(buffer_opamp_config_reg)})
        else $error("configuration read returned wrong data");

    a_pd_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        reference_control_reg[dac_ref_pkg::REF_POWER_DOWN_BIT] |=> internal_ref_power_down_out)
        else $error("reference power-down bit not passed to the output");

    a_cleared_normal: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        buffer_opamp_config_reg == 4'h0
            |=> buffer_opamp_mode_out == 4'h0 && opamp_input_connect_out == 16'h0000)
        else $error("cleared configuration left a buffer in op amp mode");

    a_unused_pins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        opamp_input_connect_out[15:10] == 6'h00)
        else $error("input pins above 9 routed to an op amp");

    a_key_open: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        key1_ok |=> key_state_reg == dac_ref_pkg::KEY_OPEN)
        else $error("correct first key did not open the sequence");

    a_stage_staged: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        stage |=> key_state_reg == dac_ref_pkg::KEY_STAGED)
        else $error("value write after first key was not staged");

    a_early_key_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_key2 && key_state_reg != dac_ref_pkg::KEY_STAGED)
            |=> key_state_reg == dac_ref_pkg::KEY_IDLE && $stable(buffer_opamp_config_reg))
        else $error("second key without staged value was not dropped");

endmodule

//--- dac_ref_pkg.sv
// constants for the converter reference and output buffer configuration block
package dac_ref_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_REFERENCE_CONTROL   = 32'hFFFF048C;
    localparam logic [31:0] ADDR_CONVERTER_CTL_BASE  = 32'hFFFF0600;
    localparam logic [31:0] ADDR_CONVERTER_CTL_STEP  = 32'h00000008;
    localparam logic [31:0] ADDR_BUFFER_UNLOCK_FIRST = 32'hFFFF0650;
    localparam logic [31:0] ADDR_BUFFER_OPAMP_CONFIG = 32'hFFFF0654;
    localparam logic [31:0] ADDR_BUFFER_UNLOCK_SECOND = 32'hFFFF0658;
    localparam logic [31:0] ADDR_REFERENCE_STATUS    = 32'hFFFF065C;

    // ------------------------------------------------------------
    // fields, keys and reset values
    // ------------------------------------------------------------
    localparam int          REF_ENABLE_BIT       = 0;
    localparam int          REF_POWER_DOWN_BIT   = 1;
    localparam logic [1:0]  REFERENCE_CTL_MASK   = 2'h3;
    localparam logic [1:0]  REFERENCE_CTL_RESET  = 2'h0;
    localparam logic [7:0]  CONVERTER_CTL_MASK   = 8'h33;
    localparam logic [7:0]  CONVERTER_CTL_RESET  = 8'h00;
    localparam logic [3:0]  BUFFER_CONFIG_RESET  = 4'h0;
    localparam logic [15:0] UNLOCK_FIRST_KEY     = 16'h009A;
    localparam logic [15:0] UNLOCK_SECOND_KEY    = 16'h000C;
    localparam int          MAX_CONVERTERS       = 4;
    localparam int          BUFFER_CONFIG_BITS   = 4;

    // ------------------------------------------------------------
    // range field codes
    // ------------------------------------------------------------
    localparam logic [1:0]  RANGE_POWER_DOWN     = 2'h0;
    localparam logic [1:0]  RANGE_EXTERNAL       = 2'h1;
    localparam logic [1:0]  RANGE_INTERNAL       = 2'h2;
    localparam logic [1:0]  RANGE_SUPPLY         = 2'h3;

    // ------------------------------------------------------------
    // op amp input pins per output buffer (positive, negative)
    // ------------------------------------------------------------
    localparam int          OPAMP_POS_INPUT [4]  = '{0, 2, 4, 8};
    localparam int          OPAMP_NEG_INPUT [4]  = '{1, 3, 5, 9};
    localparam int          INPUT_PINS           = 16;

    typedef enum logic [1:0] {
        KEY_IDLE   = 2'b00,
        KEY_OPEN   = 2'b01,
        KEY_STAGED = 2'b10
    } key_state_t;

endpackage

//--- converter_reference_decode.sv
// per-output reference and power-down decode with registered selects
`timescale 1ns/1ps
module converter_reference_decode (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [1:0] range_in,
    input  wire logic       ref_enable_in,
    input  wire logic       ref_power_down_in,
    output logic            power_down_out,
    output logic            external_ref_out,
    output logic            internal_ref_out,
    output logic            supply_ref_out
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire internal_ok = ref_enable_in && !ref_power_down_in;
    wire sel_ext     = (range_in == dac_ref_pkg::RANGE_EXTERNAL);
    wire sel_int     = (range_in == dac_ref_pkg::RANGE_INTERNAL) && internal_ok;
    wire sel_sup     = (range_in == dac_ref_pkg::RANGE_SUPPLY);
    wire pd_next     = !(sel_ext || sel_int || sel_sup);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power_down_out   <= 1'b1;
            external_ref_out <= 1'b0;
            internal_ref_out <= 1'b0;
            supply_ref_out   <= 1'b0;
        end else begin
            power_down_out   <= pd_next;
            external_ref_out <= sel_ext;
            internal_ref_out <= sel_int;
            supply_ref_out   <= sel_sup;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_range_zero_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        range_in == 2'h0 |=> power_down_out && !internal_ref_out)
        else $error("range 00 did not power down the converter");

    a_range_one_ext: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        range_in == 2'h1 |=> external_ref_out && !power_down_out && !internal_ref_out)
        else $error("range 01 did not select the external output reference");

    a_range_supply_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        range_in == 2'h3 |=> supply_ref_out && !external_ref_out)
        else $error("range 11 did not select the analog supply");

    a_internal_route: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (range_in == 2'h2 && ref_enable_in && !ref_power_down_in) |=> internal_ref_out)
        else $error("range 10 with enabled reference did not route internal reference");

endmodule

//--- dac_buffer_reference_config_tb.sv
// self-checking testbench for the reference and buffer configuration block
`timescale 1ns/1ps
module dac_buffer_reference_config_tb;
    logic        clk_in, rst_n_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
    logic        adc_ref_internal_out, internal_ref_power_down_out, en, pd;
    logic [1:0]  htrans_in;
    logic [2:0]  hsize_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, seed, rd;
    logic [3:0]  converter_power_down_out, external_output_reference_out, v, cur;
    logic [3:0]  internal_reference_out, analog_supply_reference_out, buffer_opamp_mode_out;
    logic [15:0] opamp_input_connect_out;
    logic [7:0]  rg;
    int          n_fail, total_checks, md;

    dac_buffer_reference_config DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .adc_ref_internal_out(adc_ref_internal_out),
        .internal_ref_power_down_out(internal_ref_power_down_out),
        .converter_power_down_out(converter_power_down_out),
        .external_output_reference_out(external_output_reference_out),
        .internal_reference_out(internal_reference_out),
        .analog_supply_reference_out(analog_supply_reference_out),
        .buffer_opamp_mode_out(buffer_opamp_mode_out),
        .opamp_input_connect_out(opamp_input_connect_out)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected {power-down, external, internal, supply} of one converter
    function automatic logic [3:0] conv_exp(input logic e, p, input logic [1:0] r);
        case (r)
            2'h0: return 4'h8;
            2'h1: return 4'h4;
            2'h3: return 4'h1;
            default: return (e && !p) ? 4'h2 : 4'h8;
        endcase
    endfunction

    function automatic logic [15:0] conn_exp(input logic [3:0] c);
        return {6'h00, {2{c[3]}}, 2'h0, {2{c[2]}}, {2{c[1]}}, {2{c[0]}}};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        hsel_in   <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in  <= a;
        hwrite_in <= w;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        hsel_in   <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        r = hrdata_out;
    endtask

    task automatic check_refs();
        logic [3:0] e_pd, e_ex, e_in, e_su, x;
        logic       any_ext;
        any_ext = 1'b0;
        for (int i = 0; i < 4; i++) begin
            x = conv_exp(en, pd, rg[2*i+:2]);
            {e_pd[i], e_ex[i], e_in[i], e_su[i]} = x;
            any_ext |= (rg[2*i+:2] == 2'h1);
        end
        check(32'({converter_power_down_out, external_output_reference_out,
                   internal_reference_out, analog_supply_reference_out}),
              32'({e_pd, e_ex, e_in, e_su}));
        check(32'({adc_ref_internal_out, internal_ref_power_down_out}),
              32'({en & !pd & !any_ext, pd}));
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        results();
    end

    initial begin
        seed = 32'h00005B2C;
        {rst_n_in, hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = '0;
        hsize_in = 3'h2;
        cur = 4'h0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        @(posedge clk_in);
        check(32'(hreadyout_out), 32'h1);
        check(32'(converter_power_down_out), 32'hF);
        check(32'(buffer_opamp_mode_out), 32'h0);
        for (int m = 0; m < 16; m++) begin
            {pd, en} = {m[3], m[0]};
            rg = {6'(rnd()), m[2:1]};
            xfer(1'b1, dac_ref_pkg::ADDR_REFERENCE_CONTROL, {30'h0, pd, en}, rd);
            for (int i = 0; i < 4; i++)
                xfer(1'b1, dac_ref_pkg::ADDR_CONVERTER_CTL_BASE + 32'(8 * i),
                     (rnd() & 32'h30) | 32'(rg[2*i+:2]), rd);
            repeat (2) @(posedge clk_in);
            check_refs();
        end
        for (int i = 0; i < 4; i++)
            xfer(1'b1, dac_ref_pkg::ADDR_CONVERTER_CTL_BASE + 32'(8 * i), 32'h0, rd);
        for (int k = 0; k < 16; k++) begin
            v  = 4'(rnd());
            md = k % 4;
            if (md != 1)
                xfer(1'b1, dac_ref_pkg::ADDR_BUFFER_UNLOCK_FIRST, 32'h9A, rd);
            if (md == 3)
                xfer(1'b1, dac_ref_pkg::ADDR_BUFFER_UNLOCK_SECOND, 32'h0C, rd);
            xfer(1'b1, dac_ref_pkg::ADDR_BUFFER_OPAMP_CONFIG, 32'(v), rd);
            xfer(1'b1, dac_ref_pkg::ADDR_BUFFER_UNLOCK_SECOND, (md == 2) ? 32'h0D : 32'h0C, rd);
            if (md == 0)
                cur = v;
            repeat (2) @(posedge clk_in);
            check(32'(buffer_opamp_mode_out), 32'(cur));
            check(32'(opamp_input_connect_out), 32'(conn_exp(cur)));
            xfer(1'b0, dac_ref_pkg::ADDR_BUFFER_OPAMP_CONFIG, 32'h0, rd);
            check(rd, 32'(cur));
        end
        xfer(1'b0, 32'hFFFF0700, 32'h0, rd);
        check(rd, 32'h0);
        xfer(1'b0, dac_ref_pkg::ADDR_BUFFER_UNLOCK_FIRST, 32'h0, rd);
        check(rd, 32'h0);
        check(32'(hresp_out), 32'h0);
        xfer(1'b0, dac_ref_pkg::ADDR_REFERENCE_STATUS, 32'h0, rd);
        check(rd, 32'({pd, en & !pd, 2'h0, cur}));
        xfer(1'b0, dac_ref_pkg::ADDR_REFERENCE_CONTROL, 32'h0, rd);
        check(rd, 32'({pd, en}));
        check(32'(converter_power_down_out), 32'hF);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        check(32'({buffer_opamp_mode_out, converter_power_down_out}), 32'h0F);
        results();
    end
endmodule
